// *** hdl/bddcr_pkg.sv ***
// Purpose: constants for the bar decode, dma channel and control registers
// Assumes: single-dword target accesses, dword-aligned dma transfers
// Notes: offsets are byte offsets inside the control window
// Overview of operation
// - bar pairs 1:0 and 5:4 reach target ram
// - bar pair 3:2 reaches control registers
// - rom and i/o windows get no response
// - offset 0x00 holds host address low word
// - offset 0x04 holds host address high word
// - offset 0x08 holds transfer byte count
// - a write to 0x0C with byte enables launches the dma when idle and length is nonzero
// - control bit 31 reads busy, read only
// - bit 22 selects incrementing dword write data
// - bit 21 selects incrementing byte write data
// - bit 20 selects all zero write data
// - bit 15 drives header digest bit
// - bit 14 drives header poisoned bit
// - reads through windows return a completion
// - field 6:5 sets format and direction
// - 0x14 gives master address bits 14:3
package bddcr_pkg;
  localparam logic [7:0] OFF_HOST_LO = 8'h00;
  localparam logic [7:0] OFF_HOST_HI = 8'h04;
  localparam logic [7:0] OFF_LENGTH = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_MST_ADDR = 8'h14;
  localparam int CTRL_BUSY_BIT = 31;
  localparam int CTRL_DWPAT_BIT = 22;
  localparam int CTRL_BYTEPAT_BIT = 21;
  localparam int CTRL_ZERO_BIT = 20;
  localparam int CTRL_SIZE_LSB = 16;
  localparam int CTRL_TD_BIT = 15;
  localparam int CTRL_EP_BIT = 14;
  localparam int CTRL_RO_BIT = 13;
  localparam int CTRL_NS_BIT = 12;
  localparam int CTRL_TC_LSB = 8;
  localparam int CTRL_FMT_LSB = 5;
  localparam int CTRL_WRITE_BIT = 6;
  localparam int CTRL_TYPE_LSB = 0;
  localparam logic [31:0] CTRL_WR_MASK = 32'h0077F77F;
  localparam logic [31:0] MST_WR_MASK = 32'h00007FF8;
  localparam logic [31:0] REG_RESET = 32'h00000000;
  localparam logic [12:0] SIZE_MIN_BYTES = 13'h0080;
  localparam logic [2:0] SIZE_CODE_MAX = 3'h4;
  localparam logic [5:0] BAR_RAM_MASK = 6'h33;
  localparam logic [5:0] BAR_REG_MASK = 6'h0C;
endpackage : bddcr_pkg

// *** hdl/bddcr_mem.sv ***
// Purpose: single port byte-writable ram with registered read data
// Assumes: read data follow the address by one clock
// Notes: a write and a read of one word in one cycle returns old data
`timescale 1ns/1ps
module bddcr_mem #(
  parameter int AW = 13
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_we,
  input wire logic [3:0] i_be,
  input wire logic [AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  // one array per lane so that no two processes write the same memory
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      logic [7:0] lane [0:(1<<AW)-1];
      always_ff @(posedge i_clk)
      begin
        if (i_we && i_be[g])
          lane[i_addr] <= i_wdata[8*g +: 8];
      end
      always_ff @(posedge i_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          o_rdata[8*g +: 8] <= 8'h00;
        else
          o_rdata[8*g +: 8] <= lane[i_addr];
      end
    end
  endgenerate
endmodule : bddcr_mem

// *** hdl/bddcr_top.sv ***
// Purpose: bar decode, target ram, control registers and one dma channel
// Assumes: one request presented at a time on each handshake port
// Notes: control writes while busy are ignored to keep attributes stable
`timescale 1ns/1ps
module bddcr_top #(
  parameter int RAM_AW = 13
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_RX_VALID,
  output logic O_RX_READY,
  input wire logic [5:0] I_RX_BAR_HIT,
  input wire logic I_RX_WRITE,
  input wire logic [31:0] I_RX_ADDR,
  input wire logic [31:0] I_RX_DATA,
  input wire logic [3:0] I_RX_BE,
  input wire logic [7:0] I_RX_TAG,
  output logic O_CPL_VALID,
  input wire logic I_CPL_READY,
  output logic [31:0] O_CPL_DATA,
  output logic [7:0] O_CPL_TAG,
  input wire logic [2:0] I_MAX_PAYLOAD,
  input wire logic [2:0] I_MAX_READ_REQ,
  output logic O_REQ_VALID,
  input wire logic I_REQ_READY,
  output logic [1:0] O_REQ_FMT,
  output logic [4:0] O_REQ_TYPE,
  output logic [2:0] O_REQ_TC,
  output logic O_REQ_TD,
  output logic O_REQ_EP,
  output logic [1:0] O_REQ_ATTR,
  output logic [63:0] O_REQ_ADDR,
  output logic [12:0] O_REQ_BYTES,
  output logic O_WD_VALID,
  input wire logic I_WD_READY,
  output logic [31:0] O_WD_DATA,
  output logic O_WD_LAST,
  input wire logic I_RD_VALID,
  input wire logic [31:0] I_RD_DATA
);
  typedef enum logic [1:0] {S_IDLE, S_RAMRD, S_CPL} bddcr_slv_e;
  typedef enum logic [2:0] {D_IDLE, D_CALC, D_REQ, D_WFETCH, D_WLOAD,
                            D_WDATA, D_RWAIT, D_NEXT} bddcr_dma_e;

  bddcr_slv_e slv_reg, slv_next;
  bddcr_dma_e dma_reg, dma_next;
  logic [31:0] host_lo_reg, host_lo_next, host_hi_reg, host_hi_next;
  logic [31:0] len_reg, len_next, ctrl_reg, ctrl_next, mst_reg, mst_next;
  logic [31:0] cpl_data_reg, cpl_data_next;
  logic [7:0] cpl_tag_reg, cpl_tag_next;
  logic [63:0] cur_host_reg, cur_host_next;
  logic [31:0] rem_reg, rem_next;
  logic [12:0] chunk_reg, chunk_next;
  logic [9:0] words_reg, words_next;
  logic [RAM_AW-1:0] mst_idx_reg, mst_idx_next;
  logic [31:0] wd_data_reg, wd_data_next, dwpat_reg, dwpat_next;
  logic [7:0] bpat_reg, bpat_next;
  logic [31:0] ram_rdata, mst_rdata;
  logic accept, hit_ram, hit_reg, reg_wr, start, busy;
  logic [7:0] offset;
  logic [2:0] eff_code;
  logic [12:0] lim_bytes;
  logic [13:0] words_tmp;
  logic [14:0] mst_start;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be,
                                        input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = (d[8*i +: 8] & m[8*i +: 8]) |
                      (old[8*i +: 8] & ~m[8*i +: 8]);
    end
    return r;
  endfunction : merge

  function automatic logic [2:0] clamp(input logic [2:0] c);
    return (c > bddcr_pkg::SIZE_CODE_MAX) ? bddcr_pkg::SIZE_CODE_MAX : c;
  endfunction : clamp

  assign busy = (dma_reg != D_IDLE);
  assign offset = {I_RX_ADDR[7:2], 2'b00};
  assign O_RX_READY = (slv_reg == S_IDLE);
  assign accept = I_RX_VALID && O_RX_READY;
  // rom and i/o hits match neither mask and are simply dropped
  assign hit_ram = |(I_RX_BAR_HIT & bddcr_pkg::BAR_RAM_MASK);
  assign hit_reg = |(I_RX_BAR_HIT & bddcr_pkg::BAR_REG_MASK);
  assign reg_wr = accept && I_RX_WRITE && hit_reg;
  assign start = reg_wr && (offset == bddcr_pkg::OFF_CTRL) && (|I_RX_BE)
                 && !busy;

  // bits 15 and up of the address never reach the ram
  bddcr_mem #(.AW(RAM_AW)) u_target (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_we(accept && I_RX_WRITE && hit_ram),
    .i_be(I_RX_BE),
    .i_addr(I_RX_ADDR[RAM_AW+1:2]),
    .i_wdata(I_RX_DATA),
    .o_rdata(ram_rdata)
  );

  bddcr_mem #(.AW(RAM_AW)) u_master (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_we((dma_reg == D_RWAIT) && I_RD_VALID),
    .i_be(4'hF),
    .i_addr(mst_idx_reg),
    .i_wdata(I_RD_DATA),
    .o_rdata(mst_rdata)
  );

  // register file and target slave
  always_comb
  begin
    host_lo_next = host_lo_reg;
    host_hi_next = host_hi_reg;
    len_next = len_reg;
    ctrl_next = ctrl_reg;
    mst_next = mst_reg;
    slv_next = slv_reg;
    cpl_data_next = cpl_data_reg;
    cpl_tag_next = cpl_tag_reg;
    if (reg_wr)
    begin
      unique case (offset)
        bddcr_pkg::OFF_HOST_LO:
          host_lo_next = merge(host_lo_reg, I_RX_DATA, I_RX_BE,
                               32'hFFFFFFFF);
        bddcr_pkg::OFF_HOST_HI:
          host_hi_next = merge(host_hi_reg, I_RX_DATA, I_RX_BE,
                               32'hFFFFFFFF);
        bddcr_pkg::OFF_LENGTH:
          len_next = merge(len_reg, I_RX_DATA, I_RX_BE, 32'hFFFFFFFF);
        bddcr_pkg::OFF_CTRL:
          if (!busy)
            ctrl_next = merge(ctrl_reg, I_RX_DATA, I_RX_BE,
                              bddcr_pkg::CTRL_WR_MASK);
        bddcr_pkg::OFF_MST_ADDR:
          mst_next = merge(mst_reg, I_RX_DATA, I_RX_BE,
                           bddcr_pkg::MST_WR_MASK);
        default: ;
      endcase
    end
    unique case (slv_reg)
      S_IDLE:
        if (accept && !I_RX_WRITE && (hit_ram || hit_reg))
        begin
          cpl_tag_next = I_RX_TAG;
          if (hit_ram)
            slv_next = S_RAMRD;
          else
          begin
            slv_next = S_CPL;
            unique case (offset)
              bddcr_pkg::OFF_HOST_LO: cpl_data_next = host_lo_reg;
              bddcr_pkg::OFF_HOST_HI: cpl_data_next = host_hi_reg;
              bddcr_pkg::OFF_LENGTH: cpl_data_next = len_reg;
              bddcr_pkg::OFF_CTRL:
                cpl_data_next = {busy, ctrl_reg[30:0]};
              bddcr_pkg::OFF_MST_ADDR: cpl_data_next = mst_reg;
              default: cpl_data_next = 32'h00000000;
            endcase
          end
        end
      S_RAMRD:
      begin
        cpl_data_next = ram_rdata;
        slv_next = S_CPL;
      end
      S_CPL:
        if (I_CPL_READY)
          slv_next = S_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      host_lo_reg <= bddcr_pkg::REG_RESET;
      host_hi_reg <= bddcr_pkg::REG_RESET;
      len_reg <= bddcr_pkg::REG_RESET;
      ctrl_reg <= bddcr_pkg::REG_RESET;
      mst_reg <= bddcr_pkg::REG_RESET;
      slv_reg <= S_IDLE;
      cpl_data_reg <= 32'h00000000;
      cpl_tag_reg <= 8'h00;
    end
    else
    begin
      host_lo_reg <= host_lo_next;
      host_hi_reg <= host_hi_next;
      len_reg <= len_next;
      ctrl_reg <= ctrl_next;
      mst_reg <= mst_next;
      slv_reg <= slv_next;
      cpl_data_reg <= cpl_data_next;
      cpl_tag_reg <= cpl_tag_next;
    end
  end

  assign O_CPL_VALID = (slv_reg == S_CPL);
  assign O_CPL_DATA = cpl_data_reg;
  assign O_CPL_TAG = cpl_tag_reg;

  // smallest of the control cap and both configuration limits
  always_comb
  begin
    eff_code = clamp(ctrl_reg[bddcr_pkg::CTRL_SIZE_LSB +: 3]);
    if (clamp(I_MAX_PAYLOAD) < eff_code)
      eff_code = clamp(I_MAX_PAYLOAD);
    if (clamp(I_MAX_READ_REQ) < eff_code)
      eff_code = clamp(I_MAX_READ_REQ);
  end
  assign lim_bytes = bddcr_pkg::SIZE_MIN_BYTES << eff_code;
  assign mst_start = {mst_reg[14:3], host_lo_reg[2:0]};

  // dma channel
  always_comb
  begin
    dma_next = dma_reg;
    cur_host_next = cur_host_reg;
    rem_next = rem_reg;
    chunk_next = chunk_reg;
    words_next = words_reg;
    mst_idx_next = mst_idx_reg;
    wd_data_next = wd_data_reg;
    dwpat_next = dwpat_reg;
    bpat_next = bpat_reg;
    words_tmp = {1'b0, chunk_reg} + 14'h0003;
    unique case (dma_reg)
      D_IDLE:
        if (start && (len_reg != 32'h00000000))
        begin
          cur_host_next = {host_hi_reg, host_lo_reg};
          rem_next = len_reg;
          mst_idx_next = mst_start[RAM_AW+1:2];
          dwpat_next = 32'h00000000;
          bpat_next = 8'h00;
          dma_next = D_CALC;
        end
      D_CALC:
      begin
        chunk_next = (rem_reg < {19'h00000, lim_bytes}) ?
                     rem_reg[12:0] : lim_bytes;
        dma_next = D_REQ;
      end
      D_REQ:
      begin
        words_next = words_tmp[11:2];
        if (I_REQ_READY)
          dma_next = ctrl_reg[bddcr_pkg::CTRL_WRITE_BIT] ?
                     D_WFETCH : D_RWAIT;
      end
      D_WFETCH:
        dma_next = D_WLOAD;
      D_WLOAD:
      begin
        dma_next = D_WDATA;
        if (ctrl_reg[bddcr_pkg::CTRL_DWPAT_BIT])
          wd_data_next = dwpat_reg;
        else if (ctrl_reg[bddcr_pkg::CTRL_BYTEPAT_BIT])
          wd_data_next = {bpat_reg + 8'h03, bpat_reg + 8'h02,
                          bpat_reg + 8'h01, bpat_reg};
        else if (ctrl_reg[bddcr_pkg::CTRL_ZERO_BIT])
          wd_data_next = 32'h00000000;
        else
          wd_data_next = mst_rdata;
      end
      D_WDATA:
        if (I_WD_READY)
        begin
          dwpat_next = dwpat_reg + 32'h00000001;
          bpat_next = bpat_reg + 8'h04;
          mst_idx_next = mst_idx_reg + 1'b1;
          words_next = words_reg - 10'h001;
          dma_next = (words_reg == 10'h001) ? D_NEXT : D_WFETCH;
        end
      D_RWAIT:
        if (I_RD_VALID)
        begin
          mst_idx_next = mst_idx_reg + 1'b1;
          words_next = words_reg - 10'h001;
          if (words_reg == 10'h001)
            dma_next = D_NEXT;
        end
      D_NEXT:
      begin
        cur_host_next = cur_host_reg + {51'h0, chunk_reg};
        rem_next = rem_reg - {19'h00000, chunk_reg};
        dma_next = (rem_reg == {19'h00000, chunk_reg}) ? D_IDLE : D_CALC;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      dma_reg <= D_IDLE;
      cur_host_reg <= 64'h0000000000000000;
      rem_reg <= 32'h00000000;
      chunk_reg <= 13'h0000;
      words_reg <= 10'h000;
      mst_idx_reg <= '0;
      wd_data_reg <= 32'h00000000;
      dwpat_reg <= 32'h00000000;
      bpat_reg <= 8'h00;
    end
    else
    begin
      dma_reg <= dma_next;
      cur_host_reg <= cur_host_next;
      rem_reg <= rem_next;
      chunk_reg <= chunk_next;
      words_reg <= words_next;
      mst_idx_reg <= mst_idx_next;
      wd_data_reg <= wd_data_next;
      dwpat_reg <= dwpat_next;
      bpat_reg <= bpat_next;
    end
  end

  assign O_REQ_VALID = (dma_reg == D_REQ);
  assign O_REQ_FMT = ctrl_reg[bddcr_pkg::CTRL_FMT_LSB +: 2];
  assign O_REQ_TYPE = ctrl_reg[bddcr_pkg::CTRL_TYPE_LSB +: 5];
  assign O_REQ_TC = ctrl_reg[bddcr_pkg::CTRL_TC_LSB +: 3];
  assign O_REQ_TD = ctrl_reg[bddcr_pkg::CTRL_TD_BIT];
  assign O_REQ_EP = ctrl_reg[bddcr_pkg::CTRL_EP_BIT];
  assign O_REQ_ATTR = {ctrl_reg[bddcr_pkg::CTRL_RO_BIT],
                       ctrl_reg[bddcr_pkg::CTRL_NS_BIT]};
  assign O_REQ_ADDR = cur_host_reg;
  assign O_REQ_BYTES = chunk_reg;
  assign O_WD_VALID = (dma_reg == D_WDATA);
  assign O_WD_DATA = wd_data_reg;
  assign O_WD_LAST = (dma_reg == D_WDATA) && (words_reg == 10'h001);
endmodule : bddcr_top

// *** sim/bddcr_checker.sv ***
// Purpose: port checker for bddcr_top
// Assumes: one clock, async active low reset
// Notes: sees only the top ports
`timescale 1ns/1ps
module bddcr_checker (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_RX_VALID,
  input wire logic O_RX_READY,
  input wire logic [5:0] I_RX_BAR_HIT,
  input wire logic I_RX_WRITE,
  input wire logic [7:0] I_RX_TAG,
  input wire logic O_CPL_VALID,
  input wire logic I_CPL_READY,
  input wire logic [31:0] O_CPL_DATA,
  input wire logic [7:0] O_CPL_TAG,
  input wire logic [2:0] I_MAX_PAYLOAD,
  input wire logic [2:0] I_MAX_READ_REQ,
  input wire logic O_REQ_VALID,
  input wire logic I_REQ_READY,
  input wire logic [1:0] O_REQ_FMT,
  input wire logic [63:0] O_REQ_ADDR,
  input wire logic [12:0] O_REQ_BYTES,
  input wire logic O_WD_VALID,
  input wire logic I_WD_READY,
  input wire logic [31:0] O_WD_DATA
);
  logic [2:0] mn;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  // config may shrink the chunk below the control cap
  always_comb
  begin
    mn = I_MAX_PAYLOAD;
    if (I_MAX_READ_REQ < mn)
      mn = I_MAX_READ_REQ;
    if (mn > 3'h4)
      mn = 3'h4;
  end
  sequence take;
    I_RX_VALID && O_RX_READY;
  endsequence
  sequence reg_rd;
    take ##0 !I_RX_WRITE && I_RX_BAR_HIT == 6'h08;
  endsequence
  sequence ram_rd;
    take ##0 !I_RX_WRITE && I_RX_BAR_HIT == 6'h10;
  endsequence
  AST_REG_RD: assert property (reg_rd |=> O_CPL_VALID
    && O_CPL_TAG == $past(I_RX_TAG)) else $error("reg read late");
  AST_RAM_RD: assert property (ram_rd |=> !O_CPL_VALID ##1
    (O_CPL_VALID && O_CPL_TAG == $past(I_RX_TAG, 2)))
    else $error("ram read late");
  AST_DROP: assert property (take ##0 I_RX_BAR_HIT == 6'h00
    |=> !O_CPL_VALID [*2]) else $error("dropped hit answered");
  AST_CPL_HOLD: assert property (O_CPL_VALID && !I_CPL_READY
    |=> O_CPL_VALID && $stable(O_CPL_DATA)) else $error("cpl moved");
  AST_RX_BLOCK: assert property (O_CPL_VALID |-> !O_RX_READY)
    else $error("ready while cpl pending");
  AST_REQ_HOLD: assert property (O_REQ_VALID && !I_REQ_READY
    |=> O_REQ_VALID && $stable(O_REQ_ADDR)) else $error("req moved");
  AST_REQ_SIZE: assert property (O_REQ_VALID |->
    O_REQ_BYTES != 13'h0000 && O_REQ_BYTES <= (13'h0080 << mn))
    else $error("chunk too big");
  AST_WD_HOLD: assert property (O_WD_VALID && !I_WD_READY
    |=> O_WD_VALID && $stable(O_WD_DATA)) else $error("wd moved");
  AST_WD_FMT: assert property (O_WD_VALID |-> O_REQ_FMT[1])
    else $error("data on a read");
endmodule : bddcr_checker
bind bddcr_top bddcr_checker chk_i (
  .I_CLOCK, .I_RST_B, .I_RX_VALID, .O_RX_READY, .I_RX_BAR_HIT,
  .I_RX_WRITE, .I_RX_TAG, .O_CPL_VALID, .I_CPL_READY, .O_CPL_DATA,
  .O_CPL_TAG, .I_MAX_PAYLOAD, .I_MAX_READ_REQ, .O_REQ_VALID,
  .I_REQ_READY, .O_REQ_FMT, .O_REQ_ADDR, .O_REQ_BYTES, .O_WD_VALID,
  .I_WD_READY, .O_WD_DATA
);

// *** sim/bddcr_core_model.sv ***
// Purpose: link core stand-in on the dma side
// Assumes: one read header outstanding at a time
// Notes: stalls one cycle in four to exercise holds
`timescale 1ns/1ps
module bddcr_core_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_fmt,
  input wire logic [12:0] i_req_bytes,
  output logic o_req_ready,
  output logic o_wd_ready,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data
);
  logic [1:0] cnt_reg;
  logic [7:0] pend_reg, k_reg;
  assign o_req_ready = cnt_reg != 2'h0;
  assign o_wd_ready = cnt_reg != 2'h1;
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      cnt_reg <= 2'h0;
      pend_reg <= 8'h00;
      k_reg <= 8'h00;
      o_rd_valid <= 1'b0;
      o_rd_data <= 32'h00000000;
    end
    else
    begin
      cnt_reg <= cnt_reg + 2'h1;
      o_rd_valid <= pend_reg != 8'h00;
      // idle data is scrambled so stale words never look valid
      o_rd_data <= ~o_rd_data;
      if (pend_reg != 8'h00)
      begin
        o_rd_data <= {24'h5A0000, k_reg};
        pend_reg <= pend_reg - 8'h01;
        k_reg <= k_reg + 8'h01;
      end
      if (i_req_valid && o_req_ready && !i_req_fmt[1])
        pend_reg <= 8'((i_req_bytes + 13'h0003) >> 2);
    end
endmodule : bddcr_core_model

// *** sim/test_bddcr_top.sv ***
// Purpose: self-checking bench for bddcr_top
// Assumes: core model answers the dma side
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module test_bddcr_top;
  typedef struct {logic [7:0] o; logic [31:0] d, e;} bddcr_row_s;
  typedef struct {logic [31:0] c, w0, w1;} bddcr_dma_s;
  logic clk = 0, rst_b = 0, rxv = 0, wr = 0, cr = 0;
  logic [5:0] bar = 0;
  logic [3:0] be = 4'hF;
  logic [31:0] ad = 0, dt = 0, q, cd, wdd, rdd;
  logic [7:0] tg = 0, ct;
  logic [2:0] mp = 3'h4, mr = 3'h4;
  logic rdy, cv, rqv, rqr, wdv, wdr, wdl, rdv, td, ep;
  logic [9:0] hx;
  logic [1:0] fmt, at;
  logic [4:0] ty;
  logic [2:0] tc;
  logic [3:0] hd;
  logic [12:0] rqb, lb;
  logic [63:0] rqa, la;
  int fails = 0, tests_run = 0, nreq, nlast;
  logic [31:0] words[$];
  bddcr_row_s rows[6] = '{'{8'h00, 32'hFFFFFFFF, 32'hFFFFFFFF},
    '{8'h04, 32'hA5A5A5A5, 32'hA5A5A5A5}, '{8'h08, 0, 0},
    '{8'h0C, 32'hFFFFFFFF, 32'h0077F77F},
    '{8'h14, 32'hFFFFFFFF, 32'h00007FF8}, '{8'h10, 32'hFFFFFFFF, 0}};
  bddcr_dma_s wm[4] = '{'{32'h0040F540, 0, 1},
    '{32'h00200040, 32'h03020100, 32'h07060504}, '{32'h00100040, 0, 0},
    '{32'h00000040, 32'h5A000000, 32'h5A000001}};
  always #10 clk = ~clk;
  bddcr_top dut (.I_CLOCK(clk), .I_RST_B(rst_b), .I_RX_VALID(rxv),
    .O_RX_READY(rdy), .I_RX_BAR_HIT(bar), .I_RX_WRITE(wr), .I_RX_ADDR(ad),
    .I_RX_DATA(dt), .I_RX_BE(be), .I_RX_TAG(tg), .O_CPL_VALID(cv),
    .I_CPL_READY(cr), .O_CPL_DATA(cd), .O_CPL_TAG(ct),
    .I_MAX_PAYLOAD(mp), .I_MAX_READ_REQ(mr), .O_REQ_VALID(rqv),
    .I_REQ_READY(rqr), .O_REQ_FMT(fmt), .O_REQ_TYPE(ty), .O_REQ_TC(tc),
    .O_REQ_TD(td), .O_REQ_EP(ep), .O_REQ_ATTR(at), .O_REQ_ADDR(rqa),
    .O_REQ_BYTES(rqb), .O_WD_VALID(wdv), .I_WD_READY(wdr),
    .O_WD_DATA(wdd), .O_WD_LAST(wdl), .I_RD_VALID(rdv), .I_RD_DATA(rdd));
  bddcr_core_model core (.i_clk(clk), .i_rst_b(rst_b), .i_req_valid(rqv),
    .i_req_fmt(fmt), .i_req_bytes(rqb), .o_req_ready(rqr),
    .o_wd_ready(wdr), .o_rd_valid(rdv), .o_rd_data(rdd));
  always @(posedge clk)
  begin
    if (rqv && rqr)
    begin
      nreq++;
      {la, lb, hd, hx} = {rqa, rqb, fmt, td, ep, ty, tc, at};
    end
    if (wdv && wdr)
    begin
      // weighted by position so a last flag on the wrong word shows
      nlast += wdl ? words.size() + 1 : 0;
      words.push_back(wdd);
    end
  end
  task automatic chk(input string n, input logic [63:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic rx(input logic [5:0] b, input logic w,
                    input logic [31:0] a, d);
    @(negedge clk);
    {rxv, bar, wr, ad, dt, tg} = {1'b1, b, w, a, d, tg + 8'h01};
    do @(posedge clk); while (rdy !== 1'b1);
    @(negedge clk);
    rxv = 0;
    if (!w)
    begin
      while (cv !== 1'b1) @(negedge clk);
      @(negedge clk);
      cr = 1;
      @(posedge clk);
      q = cd;
      @(negedge clk);
      cr = 0;
    end
  endtask : rx
  task automatic dma(input logic [31:0] c, n);
    rx(6'h04, 1, 32'h00000000, 32'h00001000);
    rx(6'h04, 1, 32'h00000004, 32'h00000001);
    rx(6'h04, 1, 32'h00000014, 32'h00000000);
    rx(6'h04, 1, 32'h00000008, n);
    nreq = 0;
    nlast = 0;
    words.delete();
    rx(6'h04, 1, 32'h0000000C, c);
    rx(6'h08, 0, 32'h0000000C, 0);
    chk("busy", q[31], 1);
    while (q[31] !== 1'b0) rx(6'h08, 0, 32'h0000000C, 0);
    chk("ctrl", q, c);
  endtask : dma
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1;
    foreach (rows[i])
    begin
      rx(6'h04, 1, {24'h000000, rows[i].o}, rows[i].d);
      rx(6'h08, 0, {24'h000000, rows[i].o}, 0);
      chk("reg", q, rows[i].e);
    end
    rx(6'h01, 1, 32'h00000010, 32'h12345678);
    be = 4'h1;
    rx(6'h20, 1, 32'h00000010, 32'hAABBCCDD);
    rx(6'h00, 1, 32'h00000010, 32'h0);
    be = 4'hF;
    rx(6'h10, 0, 32'h00008010, 0);
    chk("ram", q, 32'h123456DD);
    dma(0, 8);
    chk("rdreq", nreq, 1);
    chk("rdwords", words.size(), 0);
    chk("rdhdr", la, 64'h0000000100001000);
    foreach (wm[i])
    begin
      dma(wm[i].c, 8);
      chk("w0", words[0], wm[i].w0);
      chk("w1", words[1], wm[i].w1);
      chk("hdr", hd, {wm[i].c[6:5], wm[i].c[15:14]});
      chk("adr", la, 64'h0000000100001000);
      chk("attr", hx, {wm[i].c[4:0], wm[i].c[10:8], wm[i].c[13:12]});
      chk("last", nlast, 2);
    end
    mr = 3'h0;
    dma(32'h00040000, 32'h00000180);
    chk("split", nreq, 3);
    chk("splitlen", lb, 13'h0080);
    chk("splitadr", la, 64'h0000000100001100);
    {mp, mr} = {3'h1, 3'h4};
    dma(32'h00040000, 32'h00000180);
    chk("split2", nreq, 2);
    chk("split2len", lb, 13'h0080);
    chk("split2adr", la, 64'h0000000100001100);
    @(negedge clk);
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    rx(6'h08, 0, 32'h0000000C, 0);
    chk("rst", q, 0);
    print_verdict();
  end
  initial
  begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule : test_bddcr_top
